// ---- src/cir_pkg.sv ----
// constants for the intermission and retry scheduler with message objects
// assumes a 32-bit apb slave and a bit engine that supplies bit ticks and frame events
package cir_pkg;

	// ==========================================================
	// sizes
	localparam int NUM_OBJ   = 15;
	localparam int OBJ_W     = 4;
	localparam int ID_W      = 29;
	localparam int CNT_W     = 3;
	localparam int PRESC_W   = 6;

	// ==========================================================
	// register byte offsets
	localparam logic [11:0] OFS_STATUS = 12'h000;
	localparam logic [11:0] OFS_MASK   = 12'h004;
	localparam logic [11:0] OFS_BTR1   = 12'h008;
	localparam logic [11:0] OFS_BTR3   = 12'h00c;
	localparam logic [11:0] OFS_RXID   = 12'h010;
	localparam logic [11:0] OFS_SCHED  = 12'h014;
	localparam logic [3:0]  OBJ_PAGE   = 4'h1;
	localparam logic [3:0]  OFS_O_CTRL = 4'h0;
	localparam logic [3:0]  OFS_O_ID   = 4'h4;
	localparam logic [3:0]  OFS_O_MASK = 4'h8;
	localparam logic [3:0]  OFS_O_STAT = 4'hc;

	// ==========================================================
	// field positions
	localparam int ST_RX_DONE = 0;
	localparam int ST_TX_DONE = 1;
	localparam int ST_ARB_LOST = 2;
	localparam int ST_W       = 3;
	localparam int CTRL_IDE   = 2;
	localparam int OST_RX_OK  = 0;
	localparam int OST_TX_OK  = 1;
	localparam int TRIPLE_BIT = 0;

	// ==========================================================
	// reset values and intermission thresholds in bit times
	localparam logic [ST_W-1:0]    STATUS_RST = 3'h0;
	localparam logic [ST_W-1:0]    MASK_RST   = 3'h0;
	localparam logic [CNT_W-1:0]   INTER_SHORT = 3'h3;
	localparam logic [CNT_W-1:0]   INTER_LONG  = 3'h4;

	// ==========================================================
	// types
	typedef enum logic [1:0] {
		CIR_MODE_OFF = 2'b00,
		CIR_MODE_TX  = 2'b01,
		CIR_MODE_RX  = 2'b10,
		CIR_MODE_SPY = 2'b11
	} cir_mode_type;

	typedef enum logic [1:0] {
		CIR_IDLE  = 2'b00,
		CIR_BUSY  = 2'b01,
		CIR_INTER = 2'b10
	} cir_state_type;

endpackage : cir_pkg

// ---- src/cir_top.sv ----
// intermission timing, retry spacing and receive object acceptance for a can controller
// assumes a bit engine giving a tick per bit, the sampled bus level and frame event pulses
//
// Chosen here: the register addresses and the APB slave port.
`timescale 1ns/1ps

// Function
// R1: transmit enabled during a bus frame waits for the three-bit intermission.
// R2: lost arbitration with an accepting receive object retries after three bits.
// R3: lost arbitration with no accepting object retries after four intermission bits.
// R4: software arms receive objects before the first data-length bit.
// R5: object status and receive-ok flag written right after sixth end-of-frame bit.
// R6: software re-arms receive objects within 19 or 39 bit times.
// R7: matching non-last receive object takes the frame before the last object.
// R8: last object is lowest priority; spy mode keeps only unaccepted frames.
// R9: software keeps the last object armed in spy mode permanently.
// R10: software keeps triple sampling off when the prescaler field is zero.
// R11: pending transmit stays latched while recessive intermission bits are counted.
module cir_top (
	// clock and reset
	input  wire logic                        pclk,
	input  wire logic                        presetn,
	// apb slave
	input  wire logic                        psel,
	input  wire logic                        penable,
	input  wire logic                        pwrite,
	input  wire logic [11:0]                 paddr,
	input  wire logic [31:0]                 pwdata,
	output logic                             pready,
	output logic [31:0]                      prdata,
	output logic                             pslverr,
	// bit engine events
	input  wire logic                        bit_tick,
	input  wire logic                        rx_level,
	input  wire logic                        frame_busy,
	input  wire logic                        dlc_start,
	input  wire logic                        eof6_done,
	input  wire logic                        rx_frame_good,
	input  wire logic [cir_pkg::ID_W-1:0]    rx_id,
	input  wire logic                        rx_ide,
	input  wire logic                        arb_lost,
	input  wire logic                        tx_done,
	// transmit start to the bit engine
	output logic                             tx_start,
	output logic [cir_pkg::OBJ_W-1:0]        tx_obj,
	output logic [cir_pkg::ID_W-1:0]         tx_id,
	output logic                             tx_ide,
	// timing configuration to the bit engine
	output logic [cir_pkg::PRESC_W-1:0]      bit_rate_prescaler,
	output logic                             triple_sample_select,
	// interrupt
	output logic                             irq
);
	import cir_pkg::*;

	// ==========================================================
	// storage
	cir_mode_type                obj_mode_reg [NUM_OBJ];
	logic                        obj_ide_reg  [NUM_OBJ];
	logic [ID_W-1:0]             obj_id_reg   [NUM_OBJ];
	logic [ID_W-1:0]             obj_mask_reg [NUM_OBJ];
	logic [1:0]                  obj_stat_reg [NUM_OBJ];
	logic [ST_W-1:0]             status_reg;
	logic [ST_W-1:0]             mask_reg;
	logic [PRESC_W-1:0]          btr1_reg;
	logic                        btr3_reg;
	logic [ID_W-1:0]             rxid_reg;
	cir_state_type               state_reg;
	logic [CNT_W-1:0]            cnt_reg;
	logic [CNT_W-1:0]            thresh_reg;
	logic                        lost_reg;
	logic                        accept_reg;
	logic [OBJ_W-1:0]            win_reg;
	logic                        tx_active_reg;
	logic [OBJ_W-1:0]            tx_obj_reg;

	// ==========================================================
	// helpers
	function automatic logic id_match(input logic [ID_W-1:0] a, input logic [ID_W-1:0] b,
			input logic [ID_W-1:0] m, input logic ia, input logic ib);
		id_match = (((a ^ b) & m) == '0) && (ia == ib);
	endfunction : id_match

	function automatic logic obj_sel(input logic [11:0] a);
		obj_sel = (a[11:8] == OBJ_PAGE) && (a[7:4] < 4'(NUM_OBJ)) && (a[1:0] == 2'b00);
	endfunction : obj_sel

	// ==========================================================
	// apb decode
	logic                        wr_en;
	logic                        rd_setup;
	logic [OBJ_W-1:0]            widx;
	logic                        wobj;
	assign wr_en    = psel && penable && pwrite;
	assign rd_setup = psel && !penable;
	assign widx     = paddr[7:4];
	assign wobj     = wr_en && obj_sel(paddr);
	assign pready   = 1'b1;

	// ==========================================================
	// acceptance: lowest matching object wins, spy object last
	logic                        any_acc;
	logic [OBJ_W-1:0]            acc_idx;
	logic                        tx_any;
	logic [OBJ_W-1:0]            tx_idx;
	always_comb begin
		any_acc = 1'b0;
		acc_idx = '0;
		tx_any  = 1'b0;
		tx_idx  = '0;
		for (int i = NUM_OBJ - 2; i >= 0; i--) begin
			if (obj_mode_reg[i] == CIR_MODE_RX &&
					id_match(obj_id_reg[i], rx_id, obj_mask_reg[i], obj_ide_reg[i], rx_ide)) begin
				any_acc = 1'b1; // [R7]
				acc_idx = OBJ_W'(i);
			end
		end
		if (!any_acc && obj_mode_reg[NUM_OBJ-1] == CIR_MODE_SPY) begin
			any_acc = 1'b1; // [R8]
			acc_idx = OBJ_W'(NUM_OBJ - 1);
		end else if (!any_acc && obj_mode_reg[NUM_OBJ-1] == CIR_MODE_RX &&
				id_match(obj_id_reg[NUM_OBJ-1], rx_id, obj_mask_reg[NUM_OBJ-1],
					obj_ide_reg[NUM_OBJ-1], rx_ide)) begin
			any_acc = 1'b1; // [R8]
			acc_idx = OBJ_W'(NUM_OBJ - 1);
		end
		for (int i = NUM_OBJ - 1; i >= 0; i--) begin
			if (obj_mode_reg[i] == CIR_MODE_TX) begin
				tx_any = 1'b1;
				tx_idx = OBJ_W'(i);
			end
		end
	end

	// ==========================================================
	// acceptance snapshot at the first data-length bit
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			accept_reg <= 1'b0;
			win_reg    <= '0;
		end else if (dlc_start) begin
			accept_reg <= any_acc; // [R4]
			win_reg    <= acc_idx;
		end else if (tx_start) begin
			accept_reg <= 1'b0;
		end
	end

	// ==========================================================
	// intermission scheduler
	logic                        start_ok;
	assign start_ok = tx_any && !tx_active_reg;
	assign tx_start = start_ok && !frame_busy &&
		((state_reg == CIR_IDLE) ||
		(state_reg == CIR_INTER && cnt_reg >= thresh_reg)); // [R1] [R11]

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			state_reg  <= CIR_IDLE;
			cnt_reg    <= '0;
			thresh_reg <= INTER_SHORT;
		end else begin
			case (state_reg)
				CIR_IDLE: begin
					if (frame_busy || tx_start) begin
						state_reg <= CIR_BUSY;
					end
				end
				CIR_BUSY: begin
					if (!frame_busy) begin
						state_reg  <= CIR_INTER;
						cnt_reg    <= '0;
						thresh_reg <= (lost_reg && !accept_reg) ? INTER_LONG : INTER_SHORT; // [R2] [R3]
					end
				end
				CIR_INTER: begin
					if (frame_busy || tx_start) begin
						state_reg <= CIR_BUSY;
					end else if (bit_tick && !rx_level) begin
						state_reg <= CIR_BUSY;
					end else if (bit_tick && cnt_reg < thresh_reg) begin
						cnt_reg <= cnt_reg + 3'h1; // [R11]
					end else if (cnt_reg >= thresh_reg && !start_ok) begin
						state_reg <= CIR_IDLE;
					end
				end
				default: begin
					state_reg <= CIR_IDLE;
				end
			endcase
		end
	end

	// ==========================================================
	// transmit tracking and lost arbitration memory
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			tx_active_reg <= 1'b0;
			tx_obj_reg    <= '0;
			lost_reg      <= 1'b0;
			tx_obj        <= '0;
			tx_id         <= '0;
			tx_ide        <= 1'b0;
		end else begin
			if (tx_start) begin
				tx_active_reg <= 1'b1;
				tx_obj_reg    <= tx_idx;
				tx_obj        <= tx_idx;
				tx_id         <= obj_id_reg[tx_idx];
				tx_ide        <= obj_ide_reg[tx_idx];
				lost_reg      <= 1'b0;
			end else if (arb_lost) begin
				tx_active_reg <= 1'b0; // [R11]
				lost_reg      <= 1'b1;
			end else if (tx_done) begin
				tx_active_reg <= 1'b0;
			end
		end
	end

	// ==========================================================
	// message objects
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			for (int i = 0; i < NUM_OBJ; i++) begin
				obj_mode_reg[i] <= CIR_MODE_OFF;
				obj_ide_reg[i]  <= 1'b0;
				obj_id_reg[i]   <= '0;
				obj_mask_reg[i] <= '0;
				obj_stat_reg[i] <= 2'h0;
			end
		end else begin
			for (int i = 0; i < NUM_OBJ; i++) begin
				if (wobj && widx == OBJ_W'(i) && paddr[3:0] == OFS_O_STAT) begin
					obj_stat_reg[i] <= obj_stat_reg[i] & ~pwdata[1:0];
				end
			end
			if (eof6_done && rx_frame_good && accept_reg) begin
				obj_stat_reg[win_reg][OST_RX_OK] <= 1'b1; // [R5]
				obj_mode_reg[win_reg] <= CIR_MODE_OFF;
			end
			if (tx_done && tx_active_reg) begin
				obj_stat_reg[tx_obj_reg][OST_TX_OK] <= 1'b1;
				obj_mode_reg[tx_obj_reg] <= CIR_MODE_OFF;
			end
			if (wobj && paddr[3:0] == OFS_O_CTRL) begin
				obj_mode_reg[widx] <= cir_mode_type'(pwdata[1:0]);
				obj_ide_reg[widx]  <= pwdata[CTRL_IDE];
			end
			if (wobj && paddr[3:0] == OFS_O_ID) begin
				obj_id_reg[widx] <= pwdata[ID_W-1:0];
			end
			if (wobj && paddr[3:0] == OFS_O_MASK) begin
				obj_mask_reg[widx] <= pwdata[ID_W-1:0];
			end
		end
	end

	// ==========================================================
	// global registers and sticky events
	logic [ST_W-1:0]             ev;
	assign ev = {arb_lost, tx_done && tx_active_reg, eof6_done && rx_frame_good && accept_reg};

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			status_reg <= STATUS_RST;
			mask_reg   <= MASK_RST;
			btr1_reg   <= '0;
			btr3_reg   <= 1'b0;
			rxid_reg   <= '0;
		end else begin
			if (wr_en && paddr == OFS_STATUS) begin
				status_reg <= (status_reg & ~pwdata[ST_W-1:0]) | ev;
			end else begin
				status_reg <= status_reg | ev;
			end
			if (wr_en && paddr == OFS_MASK) begin
				mask_reg <= pwdata[ST_W-1:0];
			end
			if (wr_en && paddr == OFS_BTR1) begin
				btr1_reg <= pwdata[PRESC_W-1:0];
			end
			if (wr_en && paddr == OFS_BTR3) begin
				btr3_reg <= pwdata[TRIPLE_BIT]; // [R10]
			end
			if (eof6_done && rx_frame_good && accept_reg) begin
				rxid_reg <= rx_id; // [R5]
			end
		end
	end

	assign bit_rate_prescaler   = btr1_reg;
	assign triple_sample_select = btr3_reg;
	assign irq                  = |(status_reg & mask_reg);

	// ==========================================================
	// read data, taken in the setup cycle
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			prdata  <= '0;
			pslverr <= 1'b0;
		end else if (rd_setup) begin
			prdata  <= '0;
			pslverr <= 1'b0;
			if (obj_sel(paddr)) begin
				case (paddr[3:0])
					OFS_O_CTRL: prdata <= {29'h0, obj_ide_reg[widx], obj_mode_reg[widx]};
					OFS_O_ID:   prdata <= {3'h0, obj_id_reg[widx]};
					OFS_O_MASK: prdata <= {3'h0, obj_mask_reg[widx]};
					default:    prdata <= {30'h0, obj_stat_reg[widx]};
				endcase
			end else begin
				case (paddr)
					OFS_STATUS: prdata <= {29'h0, status_reg};
					OFS_MASK:   prdata <= {29'h0, mask_reg};
					OFS_BTR1:   prdata <= {26'h0, btr1_reg};
					OFS_BTR3:   prdata <= {31'h0, btr3_reg};
					OFS_RXID:   prdata <= {3'h0, rxid_reg};
					OFS_SCHED:  prdata <= {24'h0, lost_reg, accept_reg, state_reg, 1'b0, cnt_reg};
					default:    pslverr <= 1'b1;
				endcase
			end
		end
	end

endmodule : cir_top

// ---- tb/cir_top_asserts.sv ----
// checker for the scheduler, configuration and interrupt ports of cir_top
// assumes it is bound onto cir_top and sees one pclk domain
`timescale 1ns/1ps
module cir_chk (
	// clock and reset
	input wire logic                       pclk,
	input wire logic                       presetn,
	// apb
	input wire logic                       psel,
	input wire logic                       penable,
	input wire logic                       pwrite,
	input wire logic [11:0]                paddr,
	input wire logic [31:0]                pwdata,
	// bit engine and outputs
	input wire logic                       bit_tick,
	input wire logic                       rx_level,
	input wire logic                       frame_busy,
	input wire logic                       tx_start,
	input wire logic [cir_pkg::ID_W-1:0]   tx_id,
	input wire logic [cir_pkg::PRESC_W-1:0] bit_rate_prescaler,
	input wire logic                       triple_sample_select,
	input wire logic                       irq
);
	import cir_pkg::*;
	logic [2:0] gap_cnt;
	logic       seen_frame;
	logic       mask_zero;
	wire        wr = psel && penable && pwrite;
	default clocking @(posedge pclk); endclocking
	default disable iff (!presetn);
	// ==========================================================
	// recessive bits since the last frame
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			gap_cnt    <= 3'h0;
			seen_frame <= 1'b0;
		end else begin
			seen_frame <= seen_frame | frame_busy;
			if (frame_busy || (bit_tick && !rx_level))
				gap_cnt <= 3'h0;
			else if (bit_tick && gap_cnt != 3'h7)
				gap_cnt <= gap_cnt + 3'h1;
		end
	end
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn)
			mask_zero <= 1'b1;
		else if (wr && paddr == OFS_MASK)
			mask_zero <= pwdata[ST_W-1:0] == 3'h0;
	end
	// ==========================================================
	// properties
	tx_idle_bus_a: assert property (tx_start |-> !frame_busy)
		else $error("transmit start while a frame is on the bus");
	tx_gap_a: assert property (tx_start && seen_frame |-> gap_cnt >= INTER_SHORT)
		else $error("transmit start before three recessive bits");
	tx_pulse_a: assert property (tx_start |=> !tx_start)
		else $error("transmit start longer than one cycle");
	tx_hold_a: assert property (!tx_start |=> $stable(tx_id))
		else $error("transmit identifier changed without a start");
	presc_cfg_a: assert property (wr && paddr == OFS_BTR1 |=> bit_rate_prescaler == $past(pwdata[5:0]))
		else $error("prescaler output not loaded");
	presc_hold_a: assert property (!(wr && paddr == OFS_BTR1) |=> $stable(bit_rate_prescaler))
		else $error("prescaler output changed without a write");
	smp_cfg_a: assert property (wr && paddr == OFS_BTR3 |=> triple_sample_select == $past(pwdata[0]))
		else $error("triple sample output not loaded");
	irq_mask_a: assert property (mask_zero |-> !irq)
		else $error("interrupt with all events masked");
	cover property (tx_start && gap_cnt == 3'h3);
	cover property (tx_start && gap_cnt == 3'h4);
	cover property ($rose(irq));
endmodule : cir_chk

bind cir_top cir_chk i_chk (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
	.pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .bit_tick(bit_tick), .rx_level(rx_level),
	.frame_busy(frame_busy), .tx_start(tx_start), .tx_id(tx_id), .irq(irq),
	.bit_rate_prescaler(bit_rate_prescaler), .triple_sample_select(triple_sample_select));

// ---- tb/cir_bus_model.sv ----
// model of the bit engine and the other nodes on the can bus
// assumes frame and gap are called right after a pclk edge
`timescale 1ns/1ps
module cir_bus_model (
	// clock and scheduler start
	input wire logic                    pclk,
	input wire logic                    tx_start,
	// bit engine events
	output logic                        bit_tick,
	output logic                        rx_level,
	output logic                        frame_busy,
	output logic                        dlc_start,
	output logic                        eof6_done,
	output logic                        rx_frame_good,
	output logic [cir_pkg::ID_W-1:0]    rx_id,
	output logic                        rx_ide,
	output logic                        arb_lost,
	output logic                        tx_done
);
	import cir_pkg::*;
	int ticks;
	int start_at;
	initial begin
		{bit_tick, dlc_start, eof6_done, rx_frame_good, rx_ide, arb_lost, tx_done} = '0;
		{rx_level, frame_busy} = 2'b10;
		rx_id = '1;
		ticks = 0;
		start_at = -1;
	end
	// tick count at which our node began its frame
	always @(posedge pclk)
		if (tx_start && start_at < 0)
			start_at <= ticks;
	task automatic frame(input logic [ID_W-1:0] id, input logic lose, input logic ok);
		{frame_busy, rx_level, arb_lost} <= {2'b10, lose};
		rx_id <= id;
		@(posedge pclk);
		arb_lost <= 1'b0;
		repeat (3) @(posedge pclk);
		dlc_start <= 1'b1;
		@(posedge pclk);
		dlc_start <= 1'b0;
		repeat (8) @(posedge pclk);
		{eof6_done, rx_frame_good, tx_done} <= {2'b11, ok};
		@(posedge pclk);
		{eof6_done, rx_frame_good, tx_done} <= 3'h0;
		repeat (2) @(posedge pclk);
		{frame_busy, rx_level} <= 2'b01;
		rx_id <= ~id;
		@(posedge pclk);
	endtask : frame
	// recessive intermission bits, four clocks apart
	task automatic gap(input int n);
		ticks = 0;
		start_at = -1;
		repeat (n) begin
			repeat (3) @(posedge pclk);
			bit_tick <= 1'b1;
			@(posedge pclk);
			bit_tick <= 1'b0;
			ticks = ticks + 1;
		end
		repeat (3) @(posedge pclk);
	endtask : gap
endmodule : cir_bus_model

// ---- tb/tb_top.sv ----
// self-checking bench for cir_top over apb with a bus model
// assumes the checker is bound from its own file
`timescale 1ns/1ps
module tb_top;
	import cir_pkg::*;
	logic               pclk, presetn, psel, penable, pwrite, pready, pslverr, perr;
	logic [11:0]        paddr;
	logic [31:0]        pwdata, prdata, rdata;
	logic               bit_tick, rx_level, frame_busy, dlc_start, eof6_done, rx_frame_good;
	logic               rx_ide, arb_lost, tx_done, tx_start, tx_ide, triple_sample_select, irq;
	logic [ID_W-1:0]    rx_id, tx_id;
	logic [OBJ_W-1:0]   tx_obj;
	logic [PRESC_W-1:0] bit_rate_prescaler;
	int                 errors, comparisons, cyc;
	cir_top i_dut (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
		.pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .pready(pready), .prdata(prdata),
		.pslverr(pslverr), .bit_tick(bit_tick), .rx_level(rx_level), .frame_busy(frame_busy),
		.dlc_start(dlc_start), .eof6_done(eof6_done), .rx_frame_good(rx_frame_good),
		.rx_id(rx_id), .rx_ide(rx_ide), .arb_lost(arb_lost), .tx_done(tx_done),
		.tx_start(tx_start), .tx_obj(tx_obj), .tx_id(tx_id), .tx_ide(tx_ide), .irq(irq),
		.bit_rate_prescaler(bit_rate_prescaler), .triple_sample_select(triple_sample_select));
	cir_bus_model i_bus (.pclk(pclk), .tx_start(tx_start), .bit_tick(bit_tick),
		.rx_level(rx_level), .frame_busy(frame_busy), .dlc_start(dlc_start),
		.eof6_done(eof6_done), .rx_frame_good(rx_frame_good), .rx_id(rx_id),
		.rx_ide(rx_ide), .arb_lost(arb_lost), .tx_done(tx_done));
	// ==========================================================
	// clock, timeout and tasks
	initial pclk = 1'b0;
	always #25 pclk = ~pclk;
	always @(posedge pclk) begin
		cyc++;
		if (cyc == 5000) begin
			errors++;
			final_report();
		end
	end
	task automatic chk(input logic [31:0] e, input logic [31:0] g);
		comparisons++;
		if (g !== e) begin
			errors++;
			$display("unexpected at %0t: expected %h got %h", $time, e, g);
		end
	endtask : chk
	task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d);
		@(posedge pclk);
		{psel, penable, pwrite, paddr, pwdata} <= {2'b10, w, a, d};
		@(posedge pclk);
		penable <= 1'b1;
		@(posedge pclk);
		while (pready !== 1'b1)
			@(posedge pclk);
		rdata = prdata;
		perr = pslverr;
		{psel, penable} <= 2'b00;
	endtask : apb
	task automatic rd(input logic [11:0] a, input logic [31:0] e);
		apb(1'b0, a, 32'h0);
		chk(e, rdata);
	endtask : rd
	task automatic wr(input logic [11:0] a, input logic [31:0] d);
		apb(1'b1, a, d);
	endtask : wr
	task automatic irq_is(input logic e);
		@(negedge pclk);
		chk({31'h0, e}, {31'h0, irq});
	endtask : irq_is
	task automatic gapchk(input logic [31:0] e);
		i_bus.gap(6);
		chk(e, i_bus.start_at);
	endtask : gapchk
	task automatic final_report();
		$display("errors %0d comparisons %0d", errors, comparisons);
		if (errors == 0 && comparisons > 0)
			$display("DONE - PASS");
		else
			$display("DONE - FAIL");
		$finish;
	endtask : final_report
	// ==========================================================
	// sequence
	initial begin
		{psel, penable, pwrite, paddr, pwdata, presetn} = '0;
		repeat (4) @(posedge pclk);
		presetn <= 1'b1;
		rd(OFS_STATUS, 32'h0);
		rd(OFS_MASK, 32'h0);
		rd(12'h0f0, 32'h0);
		chk(32'h1, {31'h0, perr});
		wr(OFS_BTR1, 32'h3f);
		wr(OFS_BTR3, 32'h1);
		rd(OFS_BTR1, 32'h3f);
		rd(OFS_BTR3, 32'h1);
		chk(32'h3f, {26'h0, bit_rate_prescaler});
		chk(32'h1, {31'h0, triple_sample_select});
		wr(OFS_MASK, 32'h1);
		wr(12'h114, 32'h123);
		wr(12'h118, 32'h1fffffff);
		wr(12'h110, 32'h2);
		fork
			i_bus.frame(29'h0aa, 1'b0, 1'b0);
			wr(12'h100, 32'h1);
		join
		gapchk(32'h3);
		chk(32'h0, {28'h0, tx_obj});
		chk(32'h0, {3'h0, tx_id});
		i_bus.frame(29'h123, 1'b1, 1'b0);
		gapchk(32'h3);
		irq_is(1'b1);
		rd(12'h11c, 32'h1);
		rd(12'h1ec, 32'h0);
		rd(12'h110, 32'h0);
		wr(12'h11c, 32'h1);
		wr(OFS_STATUS, 32'h7);
		wr(OFS_MASK, 32'h0);
		irq_is(1'b0);
		i_bus.frame(29'h055, 1'b1, 1'b0);
		gapchk(32'h4);
		wr(12'h1e0, 32'h3);
		wr(12'h110, 32'h2);
		i_bus.frame(29'h055, 1'b1, 1'b0);
		gapchk(32'h3);
		rd(12'h1ec, 32'h1);
		rd(12'h11c, 32'h0);
		irq_is(1'b0);
		wr(OFS_MASK, 32'h1);
		irq_is(1'b1);
		wr(OFS_STATUS, 32'h7);
		irq_is(1'b0);
		i_bus.frame(29'h077, 1'b0, 1'b1);
		rd(12'h10c, 32'h2);
		gapchk(32'hffffffff);
		final_report();
	end
endmodule : tb_top
